//--- inc/mvrm_pkg.sv
// Package of the measured value read map: register offsets, request and
// answer codes, limits, states and carrier structs.
// Assumes one system clock.
`default_nettype none

package mvrm_pkg;

    // ************************************************************
    // Register offsets, one float entry of two registers each.
    // ************************************************************
    localparam logic [15:0] VOLTAGE_A_N_OFS               = 16'h0001;
    localparam logic [15:0] VOLTAGE_B_N_OFS               = 16'h0003;
    localparam logic [15:0] VOLTAGE_C_N_OFS               = 16'h0005;
    localparam logic [15:0] VOLTAGE_A_B_OFS               = 16'h0007;
    localparam logic [15:0] VOLTAGE_B_C_OFS               = 16'h0009;
    localparam logic [15:0] VOLTAGE_C_A_OFS               = 16'h000b;
    localparam logic [15:0] CURRENT_A_OFS                 = 16'h000d;
    localparam logic [15:0] CURRENT_B_OFS                 = 16'h000f;
    localparam logic [15:0] CURRENT_C_OFS                 = 16'h0011;
    localparam logic [15:0] APPARENT_POWER_A_OFS          = 16'h0013;
    localparam logic [15:0] APPARENT_POWER_B_OFS          = 16'h0015;
    localparam logic [15:0] APPARENT_POWER_C_OFS          = 16'h0017;
    localparam logic [15:0] ACTIVE_POWER_A_OFS            = 16'h0019;
    localparam logic [15:0] ACTIVE_POWER_B_OFS            = 16'h001b;
    localparam logic [15:0] ACTIVE_POWER_C_OFS            = 16'h001d;
    localparam logic [15:0] REACTIVE_POWER_A_OFS          = 16'h001f;
    localparam logic [15:0] REACTIVE_POWER_B_OFS          = 16'h0021;
    localparam logic [15:0] REACTIVE_POWER_C_OFS          = 16'h0023;
    localparam logic [15:0] NEUTRAL_CURRENT_OFS           = 16'h0025;
    localparam logic [15:0] LINE_FREQUENCY_OFS            = 16'h0027;
    localparam logic [15:0] TOTAL_APPARENT_POWER_OFS      = 16'h002f;
    localparam logic [15:0] TOTAL_ACTIVE_POWER_OFS        = 16'h0031;
    localparam logic [15:0] TOTAL_REACTIVE_POWER_OFS      = 16'h0033;
    localparam logic [15:0] TOTAL_POWER_FACTOR_OFS        = 16'h0035;
    localparam logic [15:0] PEAK_VOLTAGE_A_N_OFS          = 16'h0037;
    localparam logic [15:0] PEAK_VOLTAGE_B_N_OFS          = 16'h0039;
    localparam logic [15:0] PEAK_VOLTAGE_C_N_OFS          = 16'h003b;
    localparam logic [15:0] PEAK_VOLTAGE_A_B_OFS          = 16'h003d;
    localparam logic [15:0] PEAK_VOLTAGE_B_C_OFS          = 16'h003f;
    localparam logic [15:0] PEAK_VOLTAGE_C_A_OFS          = 16'h0041;
    localparam logic [15:0] PEAK_CURRENT_A_OFS            = 16'h0043;
    localparam logic [15:0] PEAK_CURRENT_B_OFS            = 16'h0045;
    localparam logic [15:0] PEAK_CURRENT_C_OFS            = 16'h0047;
    localparam logic [15:0] PEAK_APPARENT_POWER_A_OFS     = 16'h0049;
    localparam logic [15:0] PEAK_APPARENT_POWER_B_OFS     = 16'h004b;
    localparam logic [15:0] PEAK_APPARENT_POWER_C_OFS     = 16'h004d;
    localparam logic [15:0] PEAK_ACTIVE_POWER_A_OFS       = 16'h004f;
    localparam logic [15:0] PEAK_ACTIVE_POWER_B_OFS       = 16'h0051;
    localparam logic [15:0] PEAK_ACTIVE_POWER_C_OFS       = 16'h0053;
    localparam logic [15:0] PEAK_REACTIVE_POWER_A_OFS     = 16'h0055;
    localparam logic [15:0] PEAK_REACTIVE_POWER_B_OFS     = 16'h0057;
    localparam logic [15:0] PEAK_REACTIVE_POWER_C_OFS     = 16'h0059;
    localparam logic [15:0] PEAK_NEUTRAL_CURRENT_OFS      = 16'h005b;
    localparam logic [15:0] PEAK_LINE_FREQUENCY_OFS       = 16'h005d;
    localparam logic [15:0] PEAK_TOTAL_APPARENT_POWER_OFS = 16'h0065;
    localparam logic [15:0] PEAK_TOTAL_ACTIVE_POWER_OFS   = 16'h0067;

    // ************************************************************
    // Map geometry: first and last register, the two gaps.
    // ************************************************************
    localparam int          MVRM_ENTRIES  = 46;
    localparam logic [16:0] MAP_FIRST_REG = 17'h0_0001;
    localparam logic [16:0] MAP_LAST_REG  = 17'h0_0068;
    localparam logic [16:0] GAP1_LO_REG   = 17'h0_0029;
    localparam logic [16:0] GAP1_HI_REG   = 17'h0_002e;
    localparam logic [16:0] GAP2_LO_REG   = 17'h0_005f;
    localparam logic [16:0] GAP2_HI_REG   = 17'h0_0064;
    localparam logic [15:0] GAP1_SKIP     = 16'h0003;
    localparam logic [15:0] GAP2_SKIP     = 16'h0006;

    // ************************************************************
    // Function codes, exception codes and count limits.
    // ************************************************************
    localparam logic [7:0]  FC_READ_HOLDING = 8'h03;
    localparam logic [7:0]  FC_READ_INPUT   = 8'h04;
    localparam logic [7:0]  FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0]  FC_WRITE_MULTI  = 8'h10;
    localparam logic [7:0]  FC_ERROR_FLAG   = 8'h80;
    localparam logic [7:0]  EXC_NONE        = 8'h00;
    localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;
    localparam logic [7:0]  EXC_DEV_FAIL    = 8'h04;
    localparam logic [15:0] READ_COUNT_MIN  = 16'h0001;
    localparam logic [15:0] READ_COUNT_MAX  = 16'h007d;
    localparam logic [15:0] WRITE_COUNT_MAX = 16'h007b;
    localparam logic [31:0] MEAS_RESET_VAL  = 32'h0000_0000;

    // ************************************************************
    // State encoding and carrier structs.
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_SEND  = 2'b11
    } mvrm_state_t;

    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] start;
        logic [15:0] count;
    } mvrm_req_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic        last;
        logic [7:0]  func;
        logic [7:0]  code;
        logic [15:0] data;
    } mvrm_rsp_t;

    typedef struct packed {
        logic        we;
        logic [5:0]  idx;
        logic [31:0] value;
    } mvrm_meas_t;

endpackage : mvrm_pkg

`default_nettype wire

//--- logic/mvrm_reset_sync.sv
// Reset release synchroniser of the read map.
// Assumes an async active-low reset.
`timescale 1ns/10ps
`default_nettype none

module mvrm_reset_sync
    import mvrm_pkg::*;
(
    input  wire logic clk,       // System clock.
    input  wire logic rst_n,     // Asynchronous reset, active low.
    output var  logic rst_n_sync // Reset with synchronous release.
);

    logic stage1_reg;

    // Two flops give a clean release; assertion is immediate.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            stage1_reg <= 1'b1;
            rst_n_sync <= stage1_reg;
        end
    end

endmodule : mvrm_reset_sync

`default_nettype wire

//--- logic/mvrm_addr_decode.sv
// Maps one register address of the map onto its float entry slot.
// Assumes the address lies inside the map.
`timescale 1ns/10ps
`default_nettype none

module mvrm_addr_decode
    import mvrm_pkg::*;
(
    input  wire logic [15:0] addr,    // Register address inside the map.
    output var  logic [5:0]  slot,    // Entry index 0 to 45.
    output var  logic        hi_half  // First register: upper 16 bits.
);

    logic [15:0] pair;

    // Two registers per entry; the gaps are squeezed out of the index.
    always_comb
    begin
        pair = (addr - 16'h0001) >> 1;
        if (17'(addr) > GAP2_HI_REG)
        begin
            pair = pair - GAP2_SKIP;
        end
        else if (17'(addr) > GAP1_HI_REG)
        begin
            pair = pair - GAP1_SKIP;
        end
        slot    = pair[5:0];
        hi_half = addr[0];
    end

endmodule : mvrm_addr_decode

`default_nettype wire

//--- logic/mvrm_top.sv
// Read side of the measured value register map of the meter.
// Assumes requests arrive already deframed and CRC-checked, from logic on
// CLK_SYS; answers are framed downstream.
//
// What this block does
// - Unsupported function codes are answered with exception 01.
// - While unconfigured, register reads are answered with exception 01.
// - Illegal start offset and length combinations get exception 02.
// - A wrong data length in a request gets exception 03.
// - A measurement fault in ST_CHECK, before the first word of an otherwise valid read, gets exception 04.
// - Both read functions 03 and 04 serve every entry of the map.
// - Reads starting on the second register of a value are refused.
// - Writes ending partway through a two-register value are refused.
// - Error answers echo the function code with its top bit set.
// - Register reads ask for 1 to 125 registers, else a request error.
`timescale 1ns/10ps
`default_nettype none

module mvrm_top
    import mvrm_pkg::*;
(
    input  wire logic       CLK_SYS,    // System clock, 200 MHz.
    input  wire logic       RST_N,      // Asynchronous reset, active low.
    input  wire logic       REQ_VALID,  // Request present this cycle.
    input  wire mvrm_req_t  REQ,        // Function, start offset, count.
    output var  logic       REQ_READY,  // Block can take a request.
    input  wire logic       CONFIGURED, // Device has been configured.
    input  wire logic       MEAS_FAULT, // Measurement path reports a fault.
    input  wire mvrm_meas_t MEAS,       // Update of one live measured value.
    output var  mvrm_rsp_t  RSP         // Answer word or exception.
);

    // ************************************************************
    // State of the block.
    // ************************************************************
    typedef struct packed {
        mvrm_state_t                   state;
        logic                          ready;
        mvrm_req_t                     req;
        logic [15:0]                   addr;
        logic [15:0]                   left;
        mvrm_rsp_t                     rsp;
        logic [MVRM_ENTRIES*32-1:0]    live;
        logic [MVRM_ENTRIES*32-1:0]    snap;
    } mvrm_regs_t;

    localparam mvrm_rsp_t RSP_IDLE = '{
        valid: 1'b0,
        err:   1'b0,
        last:  1'b0,
        func:  8'h00,
        code:  EXC_NONE,
        data:  16'h0000
    };

    mvrm_regs_t s_reg;
    mvrm_regs_t s_next;
    logic       rst_n_sync;

    // ************************************************************
    // Reset release and address decoder.
    // ************************************************************

    // The rest of the design sees a reset with a clean release edge.
    mvrm_reset_sync u_reset_sync (
        .clk        (CLK_SYS),
        .rst_n      (RST_N),
        .rst_n_sync (rst_n_sync)
    );

    logic [15:0] word_addr;
    logic [5:0]  word_slot;
    logic        word_hi;

    // First word from the start offset, later ones from the walk.
    assign word_addr = (s_reg.state == ST_CHECK) ? s_reg.req.start : s_reg.addr;

    mvrm_addr_decode u_addr_decode (
        .addr    (word_addr),
        .slot    (word_slot),
        .hi_half (word_hi)
    );

    // ************************************************************
    // Request checks.
    // ************************************************************
    logic        is_read;
    logic        is_write;
    logic [15:0] eff_count;
    logic [16:0] end_reg;
    logic        gap_hit;
    logic        range_bad;
    logic        count_bad;
    logic [7:0]  exc_code;
    logic [31:0] word_value;

    // Classification of the function and the span it covers.
    always_comb
    begin
        is_read   = (s_reg.req.func == FC_READ_HOLDING) ||
                    (s_reg.req.func == FC_READ_INPUT);
        is_write  = (s_reg.req.func == FC_WRITE_SINGLE) ||
                    (s_reg.req.func == FC_WRITE_MULTI);
        eff_count = (s_reg.req.func == FC_WRITE_SINGLE) ? READ_COUNT_MIN
                                                        : s_reg.req.count;
        end_reg   = 17'(s_reg.req.start) + 17'(eff_count) - 17'h0_0001;
    end

    // Span checks: start on a first register, stay in the map, avoid gaps.
    always_comb
    begin
        gap_hit = ((17'(s_reg.req.start) <= GAP1_HI_REG) && (end_reg >= GAP1_LO_REG)) ||
                  ((17'(s_reg.req.start) <= GAP2_HI_REG) && (end_reg >= GAP2_LO_REG));
        range_bad = (s_reg.req.start[0] == 1'b0) ||
                    (17'(s_reg.req.start) < MAP_FIRST_REG) ||
                    (end_reg > MAP_LAST_REG) ||
                    gap_hit;
        if (is_write)
        begin
            // The map is read only, so even a whole-value write is refused.
            range_bad = range_bad || (end_reg[0] == 1'b1) || 1'b1;
        end
    end

    // Count limits differ between the read and the block write function.
    always_comb
    begin
        count_bad = 1'b0;
        if (is_read)
        begin
            count_bad = (s_reg.req.count < READ_COUNT_MIN) ||
                        (s_reg.req.count > READ_COUNT_MAX);
        end
        else if (s_reg.req.func == FC_WRITE_MULTI)
        begin
            count_bad = (s_reg.req.count < READ_COUNT_MIN) ||
                        (s_reg.req.count > WRITE_COUNT_MAX);
        end
    end

    // Exception selection in order of precedence.
    always_comb
    begin
        if (!is_read && !is_write)
        begin
            exc_code = EXC_ILL_FUNC;
        end
        else if (is_read && !CONFIGURED)
        begin
            exc_code = EXC_ILL_FUNC;
        end
        else if (count_bad)
        begin
            exc_code = EXC_ILL_VALUE;
        end
        else if (range_bad)
        begin
            exc_code = EXC_ILL_ADDR;
        end
        else if (MEAS_FAULT)
        begin
            exc_code = EXC_DEV_FAIL;
        end
        else
        begin
            exc_code = EXC_NONE;
        end
    end

    // The word sent always comes from the snapshot, never the live store.
    assign word_value = s_reg.snap[32*word_slot +: 32];

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb
    begin
        s_next           = s_reg;
        s_next.rsp       = RSP_IDLE;

        // Live values follow the measurement path.
        if (MEAS.we && (MEAS.idx < 6'(MVRM_ENTRIES)))
        begin
            s_next.live[32*MEAS.idx +: 32] = MEAS.value;
        end

        case (s_reg.state)
            ST_IDLE:
            begin
                if (REQ_VALID)
                begin
                    s_next.req   = REQ;
                    s_next.snap  = s_reg.live;
                    s_next.ready = 1'b0;
                    s_next.state = ST_CHECK;
                end
            end

            ST_CHECK:
            begin
                s_next.rsp.valid = 1'b1;
                s_next.rsp.func  = s_reg.req.func;
                if (exc_code != EXC_NONE)
                begin
                    // One-word error answer with the flagged function code.
                    s_next.rsp.err   = 1'b1;
                    s_next.rsp.last  = 1'b1;
                    s_next.rsp.code  = exc_code;
                    s_next.rsp.func  = s_reg.req.func | FC_ERROR_FLAG;
                    s_next.ready     = 1'b1;
                    s_next.state     = ST_IDLE;
                end
                else
                begin
                    // First word of the read; high half leads each float.
                    s_next.rsp.data  = word_hi ? word_value[31:16]
                                               : word_value[15:0];
                    s_next.rsp.last  = (s_reg.req.count == READ_COUNT_MIN);
                    s_next.addr      = s_reg.req.start + 16'h0001;
                    s_next.left      = s_reg.req.count - 16'h0001;
                    if (s_reg.req.count == READ_COUNT_MIN)
                    begin
                        s_next.ready = 1'b1;
                        s_next.state = ST_IDLE;
                    end
                    else
                    begin
                        s_next.state = ST_SEND;
                    end
                end
            end

            ST_SEND:
            begin
                // One register per cycle until the count is used up.
                s_next.rsp.valid = 1'b1;
                s_next.rsp.func  = s_reg.req.func;
                s_next.rsp.data  = word_hi ? word_value[31:16]
                                           : word_value[15:0];
                s_next.rsp.last  = (s_reg.left == READ_COUNT_MIN);
                s_next.addr      = s_reg.addr + 16'h0001;
                s_next.left      = s_reg.left - 16'h0001;
                if (s_reg.left == READ_COUNT_MIN)
                begin
                    s_next.ready = 1'b1;
                    s_next.state = ST_IDLE;
                end
            end

            default:
            begin
                s_next.ready = 1'b1;
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge CLK_SYS or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s_reg.state <= ST_IDLE;
            s_reg.ready <= 1'b1;
            s_reg.req   <= '0;
            s_reg.addr  <= 16'h0000;
            s_reg.left  <= 16'h0000;
            s_reg.rsp   <= RSP_IDLE;
            s_reg.live  <= {MVRM_ENTRIES{MEAS_RESET_VAL}};
            s_reg.snap  <= {MVRM_ENTRIES{MEAS_RESET_VAL}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign REQ_READY = s_reg.ready;
    assign RSP       = s_reg.rsp;

endmodule : mvrm_top

`default_nettype wire

//--- tb/mvrm_master_model.sv
// Polling master: holds one request until it is taken.
// Assumes the bench calls send.
`timescale 1ns/10ps
`default_nettype none

module mvrm_master_model
    import mvrm_pkg::*;
(
    input  wire logic      clk,       // System clock.
    input  wire logic      req_ready, // Block can take a request.
    output var  logic      req_valid, // Request present.
    output var  mvrm_req_t req        // Request fields.
);
    // Idle fields never show a real request.
    initial
    begin
        req_valid = 1'b0;
        req       = '1;
    end

    // Holds the request to the taking edge.
    task automatic send(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c);
        @(negedge clk);
        req_valid = 1'b1;
        req       = '{f, s, c};
        @(posedge clk);
        while (req_ready !== 1'b1)
            @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        req       = ~req;
    endtask : send
endmodule : mvrm_master_model

`default_nettype wire

//--- tb/mvrm_top_asserts.sv
// Checker of answer timing and exception codes.
// Bound to mvrm_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module mvrm_top_asserts
    import mvrm_pkg::*;
(
    input wire logic       CLK_SYS,    // System clock.
    input wire logic       RST_N,      // Reset, active low.
    input wire logic       REQ_VALID,  // Request present.
    input wire mvrm_req_t  REQ,        // Request fields.
    input wire logic       REQ_READY,  // Block can take a request.
    input wire logic       CONFIGURED, // Device configured.
    input wire logic       MEAS_FAULT, // Measurement fault.
    input wire mvrm_meas_t MEAS,       // Live value update.
    input wire mvrm_rsp_t  RSP         // Answer word.
);
    logic        take;
    logic        rd;
    logic        cnt_ok;
    logic        span_ok;
    logic [16:0] last_reg;

    // Request classification.
    assign take     = REQ_VALID && REQ_READY;
    assign rd       = (REQ.func == FC_READ_HOLDING) || (REQ.func == FC_READ_INPUT);
    assign cnt_ok   = (REQ.count >= READ_COUNT_MIN) && (REQ.count <= READ_COUNT_MAX);
    assign last_reg = 17'(REQ.start) + 17'(REQ.count) - 17'h0_0001;
    assign span_ok  = REQ.start[0] && (last_reg <= MAP_LAST_REG)
        && !((17'(REQ.start) <= GAP1_HI_REG) && (last_reg >= GAP1_LO_REG))
        && !((17'(REQ.start) <= GAP2_HI_REG) && (last_reg >= GAP2_LO_REG));

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    sequence s_answer;
        !REQ_READY ##1 RSP.valid;
    endsequence
    sequence s_exc(logic [7:0] c);
        RSP.valid && RSP.err && (RSP.code == c);
    endsequence

    property p_answer;
        take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    property p_err_form;
        RSP.valid && RSP.err |-> RSP.last && REQ_READY && (RSP.data == 16'h0000)
            && (RSP.func == ($past(REQ.func, 2) | FC_ERROR_FLAG));
    endproperty
    a_err_form: assert property (p_err_form) else $error("bad error word");
    property p_ill_func;
        take && !rd && (REQ.func != FC_WRITE_SINGLE) && (REQ.func != FC_WRITE_MULTI)
            |-> ##2 s_exc(EXC_ILL_FUNC);
    endproperty
    a_ill_func: assert property (p_ill_func) else $error("no code 01");
    property p_unconf;
        take && rd && !CONFIGURED |-> ##2 s_exc(EXC_ILL_FUNC);
    endproperty
    a_unconf: assert property (p_unconf) else $error("unconfigured read");
    property p_count;
        take && rd && CONFIGURED && !cnt_ok |=> ##1 s_exc(EXC_ILL_VALUE);
    endproperty
    a_count: assert property (p_count) else $error("no code 03");
    property p_span;
        take && rd && CONFIGURED && cnt_ok && !span_ok |-> ##2 s_exc(EXC_ILL_ADDR);
    endproperty
    a_span: assert property (p_span) else $error("no code 02");
    property p_write;
        take && (REQ.func == FC_WRITE_SINGLE) |-> ##2 s_exc(EXC_ILL_ADDR);
    endproperty
    a_write: assert property (p_write) else $error("write taken");
    property p_fault;
        take && rd && CONFIGURED && cnt_ok && span_ok ##1 MEAS_FAULT |=> s_exc(EXC_DEV_FAIL);
    endproperty
    a_fault: assert property (p_fault) else $error("no code 04");
    property p_good;
        take && rd && CONFIGURED && cnt_ok && span_ok ##1 !MEAS_FAULT
            |=> RSP.valid && !RSP.err && (RSP.func == $past(REQ.func, 2));
    endproperty
    a_good: assert property (p_good) else $error("good read refused");
    property p_burst;
        RSP.valid && !RSP.last |-> !REQ_READY ##1 RSP.valid;
    endproperty
    a_burst: assert property (p_burst) else $error("burst broken");
endmodule : mvrm_top_asserts

bind mvrm_top mvrm_top_asserts u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .CONFIGURED(CONFIGURED),
    .MEAS_FAULT(MEAS_FAULT), .MEAS(MEAS), .RSP(RSP));

`default_nettype wire

//--- tb/test_measured_value_read_map.sv
// Bench of the read map: reads, snapshot, exceptions.
// Assumes the master model issues requests.
`timescale 1ns/10ps
`default_nettype none

module test_measured_value_read_map
    import mvrm_pkg::*;
;
    logic        clk_sys    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        configured = 1'b1;
    logic        meas_fault = 1'b0;
    logic        req_valid;
    logic        req_ready;
    mvrm_req_t   req;
    mvrm_meas_t  meas       = '0;
    mvrm_rsp_t   rsp;
    logic [31:0] live [MVRM_ENTRIES];
    int          bad_count  = 0;
    int          checked    = 0;
    int          cycles     = 0;

    mvrm_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .CONFIGURED(configured), .MEAS_FAULT(meas_fault),
        .MEAS(meas), .RSP(rsp));
    mvrm_master_model master (.clk(clk_sys), .req_ready(req_ready),
        .req_valid(req_valid), .req(req));

    // Clock of 5 ns period.
    always #2.5 clk_sys = ~clk_sys;

    // Cuts a hang short.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Entry slot that holds register r.
    function automatic int idx_of(input logic [15:0] r);
        if (r < 16'h002f)
            return (r - 1) / 2;
        if (r < 16'h0065)
            return (r - 47) / 2 + 20;
        return (r - 101) / 2 + 44;
    endfunction : idx_of

    task automatic set_meas(input logic [5:0] i, input logic [31:0] v);
        @(negedge clk_sys);
        meas    = '{1'b1, i, v};
        live[i] = v;
        @(negedge clk_sys);
        meas    = '{1'b0, ~i, ~v};
    endtask : set_meas

    task automatic get_word(output mvrm_rsp_t w);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (rsp.valid !== 1'b1 && n < 8)
        begin
            @(negedge clk_sys);
            n++;
        end
        w = rsp;
    endtask : get_word

    // Reads every word; upd changes entry 1 after the snapshot.
    task automatic t_read(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c,
                          input logic upd);
        mvrm_rsp_t   w, e;
        logic [15:0] r;
        logic [31:0] v;
        master.send(f, s, c);
        if (upd)
            meas = '{1'b1, 6'h01, 32'h0bad_0bad};
        for (int k = 0; k < c; k++)
        begin
            r = s + k[15:0];
            v = live[idx_of(r)];
            get_word(w);
            meas.we = 1'b0;
            e = '{1'b1, 1'b0, (k == c - 1), f, EXC_NONE, (r[0] ? v[31:16] : v[15:0])};
            chk(64'(w), 64'(e));
        end
        if (upd)
            live[1] = 32'h0bad_0bad;
    endtask : t_read

    task automatic t_err(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c,
                         input logic [7:0] code);
        mvrm_rsp_t w, e;
        master.send(f, s, c);
        get_word(w);
        e = '{1'b1, 1'b1, 1'b1, f | FC_ERROR_FLAG, code, 16'h0000};
        chk(64'(w), 64'(e));
        chk(64'(req_ready), 64'h1);
    endtask : t_err

    // Main sequence.
    initial
    begin
        live = '{default: MEAS_RESET_VAL};
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_read(FC_READ_HOLDING, 16'h0001, 16'h0002, 1'b0);
        for (int i = 0; i < MVRM_ENTRIES; i++)
            set_meas(6'(i), {16'h5a00 | 16'(i), 16'ha500 | 16'(i)});
        t_read(FC_READ_INPUT, 16'h002f, 16'h0030, 1'b0);
        t_read(FC_READ_HOLDING, 16'h0065, 16'h0004, 1'b0);
        t_read(FC_READ_INPUT, 16'h0027, 16'h0001, 1'b0);
        t_read(FC_READ_INPUT, 16'h0001, 16'h0004, 1'b1);
        t_read(FC_READ_HOLDING, 16'h0003, 16'h0002, 1'b0);
        t_err(8'h02, 16'h0001, 16'h0002, EXC_ILL_FUNC);
        t_err(8'h2b, 16'h0001, 16'h0002, EXC_ILL_FUNC);
        t_err(FC_READ_HOLDING, 16'h0001, 16'h0000, EXC_ILL_VALUE);
        t_err(FC_READ_INPUT, 16'h0001, 16'h007e, EXC_ILL_VALUE);
        t_err(FC_WRITE_MULTI, 16'h0001, 16'h007c, EXC_ILL_VALUE);
        t_err(FC_WRITE_MULTI, 16'h0001, 16'h0001, EXC_ILL_ADDR);
        t_err(FC_WRITE_SINGLE, 16'h0001, 16'h0001, EXC_ILL_ADDR);
        t_err(FC_READ_HOLDING, 16'h0002, 16'h0001, EXC_ILL_ADDR);
        t_err(FC_READ_INPUT, 16'h0000, 16'h0001, EXC_ILL_ADDR);
        t_err(FC_READ_HOLDING, 16'h0067, 16'h0003, EXC_ILL_ADDR);
        t_err(FC_READ_HOLDING, 16'h0001, 16'h007d, EXC_ILL_ADDR);
        t_err(FC_READ_INPUT, 16'h002b, 16'h0001, EXC_ILL_ADDR);
        t_err(FC_READ_HOLDING, 16'h0027, 16'h0003, EXC_ILL_ADDR);
        t_err(FC_READ_INPUT, 16'h005d, 16'h0003, EXC_ILL_ADDR);
        configured = 1'b0;
        t_err(FC_READ_HOLDING, 16'h0001, 16'h0002, EXC_ILL_FUNC);
        t_err(FC_READ_INPUT, 16'h0001, 16'h0002, EXC_ILL_FUNC);
        t_err(FC_WRITE_SINGLE, 16'h0001, 16'h0001, EXC_ILL_ADDR);
        configured = 1'b1;
        meas_fault = 1'b1;
        t_err(FC_READ_INPUT, 16'h0001, 16'h0002, EXC_DEV_FAIL);
        t_err(FC_READ_HOLDING, 16'h0002, 16'h0001, EXC_ILL_ADDR);
        meas_fault = 1'b0;
        tally_and_finish();
    end
endmodule : test_measured_value_read_map

`default_nettype wire
